// ===== rtl/ecp_defs.svh
// offsets, field positions, reset values and timing counts of the unit
// assumes: included by bare name from the unit's module and the bench
`ifndef ECP_DEFS_SVH
`define ECP_DEFS_SVH
// ============================================================
// register offsets (8-bit registers)
`define ECP_A_CTRL 4'h0
`define ECP_A_DUTY 4'h1
`define ECP_A_PER 4'h2
`define ECP_A_PRE 4'h3
`define ECP_A_DEAD 4'h4
`define ECP_A_CMPL 4'h5
`define ECP_A_CMPH 4'h6
`define ECP_A_DACT 4'h7
`define ECP_A_TMR 4'h8
`define ECP_A_STAT 4'h9
// ============================================================
// control register fields
`define ECP_F_MODE 3:0
`define ECP_F_DCLO 5:4
`define ECP_F_CFG 7:6
// mode select codes
`define ECP_M_OFF 4'h0
`define ECP_M_TOG 4'h2
`define ECP_M_SET 4'h8
`define ECP_M_CLR 4'h9
`define ECP_M_SWI 4'ha
`define ECP_M_SPEV 4'hb
// ============================================================
// reset values
`define ECP_RST_CTRL 8'h00
`define ECP_RST_PER 8'hff
`define ECP_RST_DUTY 8'h00
// ============================================================
// timing: clock is the oscillator, instruction cycle is 4 of them
`define ECP_CLK_NS 50
`define ECP_TCY_NS 200
`endif

// ===== rtl/ecp_pkg.sv
// types of the enhanced capture/compare/pwm unit
// assumes: ecp_defs.svh in the include path
package ecp_pkg;
    // ============================================================
    // run state, gray along idle -> wait -> run
    typedef enum logic [1:0] {
        ECP_IDLE = 2'b00,
        ECP_WAIT = 2'b01,
        ECP_RUN = 2'b11
    } ecp_run_e;
    // ============================================================
    // whole state of the unit
    typedef struct packed {
        ecp_run_e st;
        logic [7:0] ctrl, duty_buf, per_buf;
        logic [1:0] pre;
        logic [6:0] dead_buf, dead_act;
        logic dead_pend;
        logic [15:0] cmp;
        logic [3:0] mode_act;
        logic [1:0] cfg_act, dclo_act;
        logic [7:0] duty_act, per_act, tmr;
        logic [5:0] sub;
        logic pwm, cmp_out, cmp_eq;
        logic trig, t1_rst, t3_rst, adc_go, flag_inh, cmp_evt;
        logic [3:0] abcd;
        logic [5:0] pin_o, pin_oe;
        logic ovr_o, ovr_oe;
        logic [7:0] rdata;
    } ecp_state_s;
endpackage

// ===== rtl/ecp_unit.sv
// one enhanced capture/compare/pwm unit with pin routing
// assumes: one clock at the oscillator rate, same-domain register port,
// static configuration levels and compare time bases from the same clock
//
// What this block does
// - output config plus mode select give single, dual or quad outputs
// - unit two: selector clear in single-chip mode moves A to its alternate pin
// - units one/three large package: selector picks B/C pins, D stays put
// - quad mode of units one/three overrides the shared basic compare pin with output D
// - compare uses timer one or three; pwm uses its own period timer
// - special event compare pulses a trigger on 16-bit match
// - trigger of units one/two resets the selected compare timer
// - unit two trigger starts a conversion only when converter enabled
// - unit three: code 1011 acts like 1010, no hardware trigger
// - unit two trigger reset suppresses the timer interrupt flags
// - pwm mode, config, duty and period registers reload only at the period boundary
// - dead-band delay reloads at first duty or period boundary
// - pwm waits for a timer reset, output lags one cycle
// - period is (period+1) times 4 clocks times prescale
// - on period match: clear timer, set output unless zero duty, copy duty
// - duty is duty buffer high eight bits plus control bits 5:4
// - codes 1100-1111 set polarity: bit1 for A/C, bit0 for B/D
// - config field: single, full forward, half, full reverse
// - output clears on fine duty match; duty beyond period never clears
`timescale 1ns/10ps
`include "ecp_defs.svh"
module ecp_unit #(
    parameter int UNIT = 2,
    parameter bit LARGE_PKG = 1'b1
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // device configuration levels
    input wire logic unit2_pin_route_sel,
    input wire logic unit13_pin_route_sel,
    input wire logic single_chip_mode,
    // compare time bases
    input wire logic [15:0] capture_timebase_one,
    input wire logic [15:0] capture_timebase_three,
    input wire logic cmp_timer_sel,
    input wire logic adc_enable,
    // events
    output logic spev_trigger,
    output logic capture_timebase_one_reset,
    output logic capture_timebase_three_reset,
    output logic tmr_flag_inhibit,
    output logic adc_start,
    output logic compare_event,
    // logical outputs after polarity
    output logic pwm_out_a,
    output logic pwm_out_b,
    output logic pwm_out_c,
    output logic pwm_out_d,
    // routed pins, column order of the pin table
    output logic [5:0] pin_out,
    output logic [5:0] pin_oe,
    // shared pin of the basic compare unit
    input wire logic basic_cmp_out,
    input wire logic basic_cmp_oe,
    output logic shared_pin_out,
    output logic shared_pin_oe
);
    localparam int TCY_CLKS = `ECP_TCY_NS / `ECP_CLK_NS;

    if (UNIT < 1 || UNIT > 3 || TCY_CLKS != 4) begin : g_chk
        $error("ecp_unit: UNIT must be 1..3 and cycle 4 clocks");
    end

    // ============================================================
    // helpers
    function automatic logic is_pwm(input logic [3:0] m);
        return m[3:2] == 2'b11;
    endfunction

    function automatic logic is_cmp(input logic [3:0] m);
        return m == `ECP_M_TOG || m[3:2] == 2'b10;
    endfunction

    // last sub-count of one timer increment: 4 clocks times prescale
    function automatic logic [5:0] sub_last(input logic [1:0] p);
        return p == 2'b00 ? 6'h03 : (p == 2'b01 ? 6'h0f : 6'h3f);
    endfunction

    // two fine bits below the timer: clock phase or prescaler top
    function automatic logic [1:0] fine_bits(input logic [5:0] s, input logic [1:0] p);
        return p == 2'b00 ? s[1:0] : (p == 2'b01 ? s[3:2] : s[5:4]);
    endfunction

    // ============================================================
    // state
    ecp_pkg::ecp_state_s state_reg;
    ecp_pkg::ecp_state_s state_next;

    logic [3:0] mode;
    logic tick;
    logic tb_hit;
    logic duty_hit;
    logic cmp_hit;
    logic compat;
    logic [9:0] duty_new;

    assign mode = state_reg.ctrl[`ECP_F_MODE];
    assign tick = state_reg.sub == sub_last(state_reg.pre);
    assign tb_hit = tick && state_reg.tmr == state_reg.per_act;
    assign duty_hit = {state_reg.tmr, fine_bits(state_reg.sub, state_reg.pre)}
        == {state_reg.duty_act, state_reg.dclo_act};
    assign cmp_hit = (cmp_timer_sel ? capture_timebase_three : capture_timebase_one)
        == state_reg.cmp && !state_reg.cmp_eq && is_cmp(mode);
    assign duty_new = {state_reg.duty_buf, state_reg.ctrl[`ECP_F_DCLO]};
    // units one/three fall back to a single output with selector set outside single-chip mode
    assign compat = UNIT != 2 && unit13_pin_route_sel && !single_chip_mode;

    always_comb begin
        logic [3:0] lg;
        logic [3:0] en;
        logic [1:0] cfg;
        logic [2:0] ia;
        logic [2:0] ib;
        logic [2:0] ic;
        logic [2:0] id;
        lg = 4'h0;
        en = 4'h0;
        cfg = 2'b00;
        ia = 3'h0;
        ib = 3'h1;
        ic = 3'h2;
        id = 3'h3;
        state_next = state_reg;
        state_next.trig = 1'b0;
        state_next.t1_rst = 1'b0;
        state_next.t3_rst = 1'b0;
        state_next.adc_go = 1'b0;
        state_next.flag_inh = 1'b0;
        state_next.cmp_evt = 1'b0;
        state_next.rdata = 8'h00;

        // ============================================================
        // period timer with prescaler
        state_next.sub = tick ? 6'h00 : state_reg.sub + 6'h01;
        if (tick) begin
            state_next.tmr = tb_hit ? 8'h00 : state_reg.tmr + 8'h01;
        end
        if (tb_hit) begin
            state_next.mode_act = mode;
            state_next.cfg_act = state_reg.ctrl[`ECP_F_CFG];
            state_next.per_act = state_reg.per_buf;
            state_next.duty_act = state_reg.duty_buf;
            state_next.dclo_act = state_reg.ctrl[`ECP_F_DCLO];
            state_next.pwm = duty_new != 10'h000;
        end else if (duty_hit) begin
            // duty above period never matches, so output stays set
            state_next.pwm = 1'b0;
        end
        if (state_reg.dead_pend && (tb_hit || duty_hit)) begin
            state_next.dead_act = state_reg.dead_buf;
            state_next.dead_pend = 1'b0;
        end

        // ============================================================
        // run state
        unique case (state_reg.st)
            ecp_pkg::ECP_IDLE: begin
                if (is_pwm(mode)) begin
                    state_next.st = ecp_pkg::ECP_WAIT;
                end
            end
            ecp_pkg::ECP_WAIT: begin
                if (!is_pwm(mode)) begin
                    state_next.st = ecp_pkg::ECP_IDLE;
                end else if (tb_hit) begin
                    state_next.st = ecp_pkg::ECP_RUN;
                end
            end
            ecp_pkg::ECP_RUN: begin
                if (!is_pwm(mode)) begin
                    state_next.st = ecp_pkg::ECP_IDLE;
                end
            end
            default: state_next.st = ecp_pkg::ECP_IDLE;
        endcase

        // ============================================================
        // compare and special event
        state_next.cmp_eq = (cmp_timer_sel ? capture_timebase_three
            : capture_timebase_one) == state_reg.cmp;
        if (cmp_hit) begin
            state_next.cmp_evt = 1'b1;
            if (mode == `ECP_M_SET) begin
                state_next.cmp_out = 1'b1;
            end else if (mode == `ECP_M_CLR) begin
                state_next.cmp_out = 1'b0;
            end else if (mode == `ECP_M_TOG) begin
                state_next.cmp_out = !state_reg.cmp_out;
            end else if (mode == `ECP_M_SPEV && UNIT < 3) begin
                state_next.trig = 1'b1;
                state_next.t1_rst = !cmp_timer_sel;
                state_next.t3_rst = cmp_timer_sel;
                state_next.flag_inh = UNIT == 2;
                state_next.adc_go = UNIT == 2 && adc_enable;
            end
        end

        // ============================================================
        // output waveforms
        cfg = compat ? 2'b00 : state_reg.cfg_act;
        if (state_reg.st == ecp_pkg::ECP_RUN) begin
            unique case (cfg)
                2'b00: lg = {3'b000, state_reg.pwm};
                2'b01: lg = {state_reg.pwm, 3'b001};
                2'b10: lg = {2'b00, !state_reg.pwm, state_reg.pwm};
                2'b11: lg = {2'b01, state_reg.pwm, 1'b0};
            endcase
            // d c b a; bit1 inverts A and C, bit0 inverts B and D
            lg = lg ^ {state_reg.mode_act[0], state_reg.mode_act[1],
                state_reg.mode_act[0], state_reg.mode_act[1]};
            en = cfg == 2'b00 ? 4'h1 : (cfg == 2'b10 ? 4'h3 : 4'hf);
        end else if (mode == `ECP_M_SWI || mode == `ECP_M_SPEV) begin
            // software-only compare modes hand the pin back to the port
            en = 4'h0;
        end else if (is_cmp(mode)) begin
            lg = {3'b000, state_reg.cmp_out};
            en = 4'h1;
        end

        // ============================================================
        // pin routing, columns of the pin table
        if (UNIT == 2) begin
            ia = unit2_pin_route_sel ? 3'h1 : (single_chip_mode ? 3'h2 : 3'h0);
            ib = 3'h3;
            ic = 3'h4;
            id = 3'h5;
        end else if (LARGE_PKG && !unit13_pin_route_sel) begin
            ib = 3'h4;
            ic = 3'h5;
        end
        for (int i = 0; i < 6; i++) begin
            state_next.pin_o[i] = (en[0] && ia == 3'(i)) ? lg[0]
                : (en[1] && ib == 3'(i)) ? lg[1]
                : (en[2] && ic == 3'(i)) ? lg[2]
                : (en[3] && id == 3'(i)) ? lg[3] : 1'b0;
            state_next.pin_oe[i] = (en[0] && ia == 3'(i)) || (en[1] && ib == 3'(i))
                || (en[2] && ic == 3'(i)) || (en[3] && id == 3'(i));
        end
        state_next.abcd = lg;
        // basic compare unit keeps its pin unless D of unit one or three is in use
        state_next.ovr_o = (UNIT != 2 && en[3]) ? lg[3] : basic_cmp_out;
        state_next.ovr_oe = (UNIT != 2 && en[3]) ? 1'b1 : basic_cmp_oe;

        // ============================================================
        // register port
        if (reg_wr) begin
            case (reg_addr)
                `ECP_A_CTRL: begin
                    state_next.ctrl = reg_wdata;
                    if (reg_wdata[`ECP_F_MODE] == `ECP_M_SET) begin
                        state_next.cmp_out = 1'b0;
                    end else if (reg_wdata[`ECP_F_MODE] == `ECP_M_CLR) begin
                        state_next.cmp_out = 1'b1;
                    end
                end
                `ECP_A_DUTY: state_next.duty_buf = reg_wdata;
                `ECP_A_PER: state_next.per_buf = reg_wdata;
                `ECP_A_PRE: state_next.pre = reg_wdata[1:0];
                `ECP_A_DEAD: begin
                    state_next.dead_buf = reg_wdata[6:0];
                    state_next.dead_pend = 1'b1;
                end
                `ECP_A_CMPL: state_next.cmp[7:0] = reg_wdata;
                `ECP_A_CMPH: state_next.cmp[15:8] = reg_wdata;
                default: ;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                `ECP_A_CTRL: state_next.rdata = state_reg.ctrl;
                `ECP_A_DUTY: state_next.rdata = state_reg.duty_buf;
                `ECP_A_PER: state_next.rdata = state_reg.per_buf;
                `ECP_A_PRE: state_next.rdata = {6'h00, state_reg.pre};
                `ECP_A_DEAD: state_next.rdata = {1'b0, state_reg.dead_act};
                `ECP_A_CMPL: state_next.rdata = state_reg.cmp[7:0];
                `ECP_A_CMPH: state_next.rdata = state_reg.cmp[15:8];
                `ECP_A_DACT: state_next.rdata = state_reg.duty_act;
                `ECP_A_TMR: state_next.rdata = state_reg.tmr;
                `ECP_A_STAT: state_next.rdata = {state_reg.abcd, state_reg.cmp_out,
                    state_reg.pwm, state_reg.st};
                default: state_next.rdata = 8'h00;
            endcase
        end

        // off: run state and outputs cleared, pins back to the port; timer keeps counting
        if (mode == `ECP_M_OFF) begin
            state_next.st = ecp_pkg::ECP_IDLE;
            state_next.pwm = 1'b0;
            state_next.cmp_out = 1'b0;
            state_next.abcd = 4'h0;
            state_next.pin_o = 6'h00;
            state_next.pin_oe = 6'h00;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            state_reg <= '0;
            state_reg.ctrl <= `ECP_RST_CTRL;
            state_reg.per_buf <= `ECP_RST_PER;
            state_reg.per_act <= `ECP_RST_PER;
            state_reg.duty_buf <= `ECP_RST_DUTY;
        end else begin
            state_reg <= state_next;
        end
    end

    assign reg_rdata = state_reg.rdata;
    assign spev_trigger = state_reg.trig;
    assign capture_timebase_one_reset = state_reg.t1_rst;
    assign capture_timebase_three_reset = state_reg.t3_rst;
    assign tmr_flag_inhibit = state_reg.flag_inh;
    assign adc_start = state_reg.adc_go;
    assign compare_event = state_reg.cmp_evt;
    assign pwm_out_a = state_reg.abcd[0];
    assign pwm_out_b = state_reg.abcd[1];
    assign pwm_out_c = state_reg.abcd[2];
    assign pwm_out_d = state_reg.abcd[3];
    assign pin_out = state_reg.pin_o;
    assign pin_oe = state_reg.pin_oe;
    assign shared_pin_out = state_reg.ovr_o;
    assign shared_pin_oe = state_reg.ovr_oe;

    // ============================================================
    // checks
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    sequence s_bound;
        tb_hit;
    endsequence

    sequence s_quiet;
        !tb_hit [*3];
    endsequence

    off_release_a: assert property (mode == `ECP_M_OFF && !reg_wr |=> pin_oe == 6'h00
        && state_reg.st == ecp_pkg::ECP_IDLE) else $error("off mode kept pins");
    period_wrap_a: assert property (s_bound |=> state_reg.tmr == 8'h00
        && state_reg.duty_act == $past(state_reg.duty_buf)) else $error("period wrap wrong");
    zero_duty_a: assert property ((s_bound and (duty_new == 10'h000)) |=> !state_reg.pwm)
        else $error("zero duty set output");
    period_min_a: assert property (s_bound |=> s_quiet)
        else $error("period shorter than four clocks");
    wait_reset_a: assert property (state_reg.st == ecp_pkg::ECP_WAIT && !tb_hit
        |=> state_reg.st != ecp_pkg::ECP_RUN) else $error("pwm started before timer reset");
    duty_clear_a: assert property (duty_hit && !tb_hit && mode != `ECP_M_OFF
        |=> !state_reg.pwm) else $error("duty match did not clear");
    trig_pulse_a: assert property (cmp_hit && mode == `ECP_M_SPEV && UNIT < 3
        |=> spev_trigger && (capture_timebase_one_reset != capture_timebase_three_reset)) else $error("missing trigger");
    timer_pick_a: assert property (spev_trigger |-> capture_timebase_three_reset == $past(cmp_timer_sel))
        else $error("wrong timer reset");
    adc_gate_a: assert property (adc_start |-> UNIT == 2 && $past(adc_enable))
        else $error("conversion started while disabled");
    no_trig_a: assert property (UNIT == 3 |-> !spev_trigger)
        else $error("unit three made a trigger");
    flag_inh_a: assert property (spev_trigger && UNIT == 2 |-> tmr_flag_inhibit)
        else $error("flag not suppressed");
endmodule

// ===== test/ecp_load.sv
// load on one routed pwm pin: counts high cycles and rising edges
// assumes: pin and enable come registered from the clk_sys domain
`timescale 1ns/10ps
module ecp_load (
    // clock
    input wire logic clk_sys,
    // pin and its enable
    input wire logic pin,
    input wire logic oe,
    // measure window
    input wire logic clear,
    output logic [15:0] hi_cnt,
    output logic [15:0] rise_cnt
);
    logic lvl;
    logic last;
    // ============================================================
    // level at the load
    // an unclaimed pin floats; the load's pull-down then wins
    assign lvl = oe ? pin : 1'b0;
    always @(posedge clk_sys) begin
        last <= lvl;
        if (clear) begin
            hi_cnt <= 16'h0;
            rise_cnt <= 16'h0;
        end else begin
            hi_cnt <= hi_cnt + {15'h0, lvl};
            rise_cnt <= rise_cnt + {15'h0, lvl & ~last};
        end
    end
endmodule

// ===== test/enhanced_capture_compare_pwm_bench.sv
// self-checking bench of the enhanced unit, built as unit two
// assumes: ecp_defs.svh in the include path, ecp_unit and ecp_load compiled
`timescale 1ns/10ps
`include "ecp_defs.svh"
module enhanced_capture_compare_pwm_bench;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic unit2_pin_route_sel = 1'b1;
    logic cmp_timer_sel = 1'b0;
    logic adc_enable = 1'b0;
    logic [15:0] tb1 = 16'h0;
    logic [15:0] tb3 = 16'h0;
    logic ld = 1'b0;
    logic clr = 1'b0;
    logic rd_d = 1'b0;
    logic scm = 1'b1;
    logic [1:0] bco = 2'b00;
    logic [1:0] bco_d = 2'b00;
    logic sh_out, sh_oe;
    logic [7:0] reg_rdata;
    logic spev_trigger, capture_timebase_one_reset, capture_timebase_three_reset, tmr_flag_inhibit, adc_start, compare_event;
    logic pwm_out_a;
    logic [5:0] pin_out, pin_oe;
    logic [15:0] hi_cnt, rise_cnt;
    logic [7:0] rq[$];
    logic [5:0] eq[$];
    logic [3:0] cm[4] = '{4'hb, 4'hb, 4'ha, 4'h2};
    logic [5:0] ce[4] = '{6'h37, 6'h2d, 6'h01, 6'h01};
    logic [5:0] oe_cfg[4] = '{6'h02, 6'h3a, 6'h0a, 6'h3a};
    logic [9:0] dv[5] = '{10'h005, 10'h000, 10'h3ff, 10'h008, 10'h001};
    logic [9:0] d;
    int fails = 0;
    int n_compared = 0;
    int cyc = 0;
    int i;
    // ============================================================
    // design and load
    ecp_unit #(.UNIT(2), .LARGE_PKG(1'b1)) dut (
        .clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .unit2_pin_route_sel(unit2_pin_route_sel), .unit13_pin_route_sel(1'b0),
        .single_chip_mode(scm), .capture_timebase_one(tb1), .capture_timebase_three(tb3),
        .cmp_timer_sel(cmp_timer_sel), .adc_enable(adc_enable),
        .spev_trigger(spev_trigger), .capture_timebase_one_reset(capture_timebase_one_reset), .capture_timebase_three_reset(capture_timebase_three_reset),
        .tmr_flag_inhibit(tmr_flag_inhibit), .adc_start(adc_start),
        .compare_event(compare_event), .pwm_out_a(pwm_out_a), .pwm_out_b(),
        .pwm_out_c(), .pwm_out_d(), .pin_out(pin_out), .pin_oe(pin_oe),
        .basic_cmp_out(bco[0]), .basic_cmp_oe(bco[1]), .shared_pin_out(sh_out),
        .shared_pin_oe(sh_oe)
    );
    ecp_load load (
        .clk_sys(clk_sys), .pin(pin_out[1]), .oe(pin_oe[1]), .clear(clr),
        .hi_cnt(hi_cnt), .rise_cnt(rise_cnt)
    );
    initial begin
        forever #25 clk_sys = ~clk_sys;
    end
    // ============================================================
    // checking and closing
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        if (fails == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ============================================================
    // compare time bases: reset by the unit's pulses, like the real timers
    always @(posedge clk_sys) begin
        tb1 <= ld ? 16'h1230 : (capture_timebase_one_reset ? 16'h0 : tb1 + 16'h1);
        tb3 <= ld ? 16'h1230 : (capture_timebase_three_reset ? 16'h0 : tb3 + 16'h1);
        // the basic unit's pin wanders at random; unit two never takes it
        bco <= 2'($urandom);
    end
    // ============================================================
    // result watcher: oldest note against each result seen
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        rd_d <= reg_rd;
        bco_d <= bco;
        if (cyc > 3) begin
            chk({14'h0, sh_oe, sh_out}, {14'h0, bco_d});
        end
        if (rd_d) begin
            chk({8'h0, reg_rdata}, {8'h0, rq.pop_front()});
        end
        if (compare_event || spev_trigger || adc_start) begin
            chk({10'h0, spev_trigger, capture_timebase_one_reset, capture_timebase_three_reset, tmr_flag_inhibit, adc_start,
                compare_event}, {10'h0, eq.pop_front()});
        end
        if (cyc == 20000) begin
            fails++;
            finish_test();
        end
    end
    // ============================================================
    // register port: one strobe cycle, then a quiet edge
    task automatic wr(input logic [3:0] a, input logic [7:0] dat);
        reg_addr <= a;
        reg_wdata <= dat;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        rq.push_back(exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(posedge clk_sys);
    endtask
    // window of 256 clocks: whole periods for every prescale at period 1
    task automatic meas(input logic [15:0] hi, input logic [15:0] rise);
        repeat (160) @(posedge clk_sys);
        clr <= 1'b1;
        @(posedge clk_sys);
        clr <= 1'b0;
        repeat (256) @(posedge clk_sys);
        #1;
        chk(hi_cnt, hi);
        chk(rise_cnt, rise);
        @(posedge clk_sys);
    endtask
    // ============================================================
    // main sequence
    initial begin
        void'($urandom(32'h8ab59dd6));
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        rd(`ECP_A_CTRL, `ECP_RST_CTRL);
        rd(`ECP_A_PER, `ECP_RST_PER);
        rd(4'hf, 8'h00);
        wr(4'hf, 8'h5a);
        d = 10'($urandom);
        wr(`ECP_A_DUTY, d[7:0]);
        rd(`ECP_A_DUTY, d[7:0]);
        // special event and plain compare, both timers
        wr(`ECP_A_CMPL, 8'h38);
        wr(`ECP_A_CMPH, 8'h12);
        for (i = 0; i < 4; i++) begin
            cmp_timer_sel <= i[0];
            adc_enable <= ~i[0] | i[1];
            wr(`ECP_A_CTRL, {4'h0, cm[i]});
            eq.push_back(ce[i]);
            ld <= 1'b1;
            @(posedge clk_sys);
            ld <= 1'b0;
            repeat (30) @(posedge clk_sys);
        end
        // pwm at period 1; first start waits for the old period to run out
        wr(`ECP_A_CTRL, 8'h00);
        wr(`ECP_A_PRE, 8'h00);
        wr(`ECP_A_PER, 8'h01);
        wr(`ECP_A_DUTY, 8'h00);
        wr(`ECP_A_CTRL, 8'h3c);
        repeat (20) @(posedge clk_sys);
        chk({15'h0, pwm_out_a}, 16'h0);
        rd(`ECP_A_STAT, 8'h01);
        repeat (1100) @(posedge clk_sys);
        // latch sets and clears one clock after its counts: duty plus one clock high
        meas(16'd128, 16'd32);
        dv[4] = 10'($urandom % 7 + 1);
        for (i = 0; i < 5; i++) begin
            wr(`ECP_A_DUTY, dv[i][9:2]);
            wr(`ECP_A_CTRL, {2'b00, dv[i][1:0], 4'hc});
            meas((dv[i] == 10'd0) ? 16'd0 : (dv[i] >= 10'd7) ? 16'd256
                : 16'(dv[i] + 10'd1) * 16'd32,
                (dv[i] == 10'd0 || dv[i] >= 10'd7) ? 16'd0 : 16'd32);
            rd(`ECP_A_DACT, dv[i][9:2]);
        end
        wr(`ECP_A_DUTY, 8'h00);
        wr(`ECP_A_CTRL, 8'h3c);
        for (i = 0; i < 3; i++) begin
            wr(`ECP_A_PRE, 8'(i));
            meas(16'd96 + (16'd32 >> (2 * i)), 16'd32 >> (2 * i));
        end
        wr(`ECP_A_PRE, 8'h00);
        for (i = 0; i < 4; i++) begin
            // duty one keeps the high and low counts apart under inversion
            wr(`ECP_A_CTRL, {4'h1, 2'b11, 2'(i)});
            meas(i[1] ? 16'd192 : 16'd64, 16'd32);
        end
        // output arrangement and pin routing
        for (i = 0; i < 4; i++) begin
            wr(`ECP_A_CTRL, {2'(i), 6'h3c});
            repeat (160) @(posedge clk_sys);
            chk({10'h0, pin_oe}, {10'h0, oe_cfg[i]});
        end
        wr(`ECP_A_CTRL, 8'h3c);
        unit2_pin_route_sel <= 1'b0;
        repeat (160) @(posedge clk_sys);
        chk({10'h0, pin_oe}, 16'h0004);
        scm <= 1'b0;
        repeat (4) @(posedge clk_sys);
        chk({10'h0, pin_oe}, 16'h0001);
        wr(`ECP_A_CTRL, 8'h00);
        repeat (4) @(posedge clk_sys);
        chk({10'h0, pin_oe}, 16'h0000);
        chk({15'h0, pwm_out_a}, 16'h0);
        finish_test();
    end
endmodule
